// file: hw/mcdp_defines.svh
// constants of the controller device port: selector codes, reset values,
// timing counts
// assumes inclusion by bare name from the package and the design module
`ifndef MCDP_DEFINES_SVH
`define MCDP_DEFINES_SVH

`define MCDP_BYTE_W        8
`define MCDP_NUM_OUT       6
`define MCDP_SEL_W         3
// selector codes: 0..5 output bytes one..six, 6 byte seven, 7 byte eight
`define MCDP_SEL_IN7       3'h6
`define MCDP_SEL_IN8       3'h7
`define MCDP_OUT_RST       8'h00
// input byte eight bit positions (documented bits 1..8 map to 0..7)
`define MCDP_STB_BIT       2
`define MCDP_PAR_BIT       6
`define MCDP_LF1_BIT       0
`define MCDP_LF2_BIT       1
`define MCDP_LF3_BIT       2
// clock and settle time
`define MCDP_XTAL_MHZ      20
`define MCDP_CLK_NS        10
`define MCDP_SETTLE_CYC    2

`endif

// file: hw/mcdp_pkg.sv
// types of the controller device port
// assumes mcdp_defines.svh on the include path
`include "mcdp_defines.svh"

package mcdp_pkg;

  typedef logic [`MCDP_BYTE_W-1:0] mcdp_byte_t;

  // internal action commands that touch this block
  typedef struct packed {
    logic par_set;
    logic par_clr;
    logic [2:0] lf_set;   // index 0 = line flag one
    logic [2:0] lf_clr;
    logic latch_mux_par;
  } mcdp_iac_t;

  // jump-net conditions presented to the microsequencer
  typedef struct packed {
    logic strobed_par;
    logic [2:0] line_flag;
    logic mux_par;
  } mcdp_jump_t;

  typedef struct packed {
    mcdp_byte_t [`MCDP_NUM_OUT-1:0] out_reg;
    logic [1:0][`MCDP_BYTE_W-1:0]  rx_lines_s1; // first sync stage
    logic [1:0][`MCDP_BYTE_W-1:0]  rx_lines_s2; // byte 7/8 second stage
    logic [5:0][`MCDP_BYTE_W-1:0]  fb_s1;
    logic [5:0][`MCDP_BYTE_W-1:0]  fb_s2;
    logic [3:0] edge_prev;         // stb, lf1..3 previous sample
    logic       par_raw;
    logic       par_sync;
    logic [2:0] line_flag;
    logic       mux_par;
    mcdp_byte_t rx_bus;
  } mcdp_state_t;

endpackage

// file: hw/mcdp_device_port.sv
// general-purpose device port of the microcoded controller
// assumes the microsequencer drives selector, write strobe and action
// commands on mclk, and the cable lines arrive asynchronously
//
// What this block does
// - six 8-bit output registers drive 48 device lines
// - each driven line is received back and readable by microcode
// - bytes seven and eight are input only, never driven
// - eight-to-one selector presents one received byte to the data path
// - leading edge of byte eight bit 3 captures odd parity of nine bits
// - strobed parity seen only as synchronized jump condition, not readable
// - one action command clears strobed parity, another sets it
// - microcode avoids clearing strobed parity while a strobe may arrive
// - each leading edge of byte eight bit 3 sets line flag three
// - action commands set and clear line flag three
// - byte eight bits 2 and 1 own identical line flags two and one
// - odd parity of selector output latched by command for jump test
// - selecting an output register places its contents on receive bus
// - writes come from transmit bus, reads go to receive bus
// - controller clock from a 20 MHz crystal by default
// - any selected byte can be rotated right by one bit
// - initialize clears output registers 1, 3, 5 and 6; master clear clears all six
// - microcode holds drivers two cycles, uses readback in second cycle
`timescale 1ns/1ps
`default_nettype none
`include "mcdp_defines.svh"

module mcdp_device_port
  import mcdp_pkg::*;
#(
  parameter int XTAL_MHZ = `MCDP_XTAL_MHZ  // crystal rate
) (
  input  wire logic                 mclk,        // controller clock
  input  wire logic                 rst,         // master clear, high
  input  wire logic                 init_cmd,    // initialize command pulse
  input  wire mcdp_byte_t           tx_bus,      // transmit bus data
  input  wire logic [2:0]           wr_sel,      // output register 0..5
  input  wire logic                 wr_en,       // write strobe
  input  wire logic [2:0]           rd_sel,      // device selector code
  input  wire logic                 rd_src,      // 1: register, 0: lines
  input  wire logic                 rot_en,      // rotate right one bit
  input  wire mcdp_iac_t            internal_action_command,         // action command pulses
  input  wire logic [47:0]          line_in,     // received driven lines
  input  wire mcdp_byte_t           in7,         // input-only byte seven
  input  wire mcdp_byte_t           in8,         // input-only byte eight
  output logic [47:0]               line_out,    // driver data
  output logic [47:0]               line_oe_n,   // driver enable, low on
  output mcdp_byte_t                receive_bus, // internal receive bus
  output mcdp_jump_t                jump         // jump-net conditions
);

  mcdp_state_t st_ff;
  mcdp_state_t nxt_st;

  // odd parity: 1 when the count of ones is even
  function automatic logic odd_par(input logic [8:0] v);
    return ~^v;
  endfunction

  mcdp_byte_t sel_byte;
  logic       stb_rise;
  logic [2:0] lf_rise;
  logic [8:0] par_grp;

  always_comb begin
    nxt_st = st_ff;
    sel_byte = `MCDP_OUT_RST;
    // ------------------------------------------------------------------
    // input synchronizers
    // ------------------------------------------------------------------
    nxt_st.rx_lines_s1 = {in8, in7};
    nxt_st.rx_lines_s2 = st_ff.rx_lines_s1;
    for (int i = 0; i < 6; i++) begin
      nxt_st.fb_s1[i] = line_in[i*8 +: 8];
      nxt_st.fb_s2[i] = st_ff.fb_s1[i];
    end
    nxt_st.edge_prev = {st_ff.rx_lines_s2[1][`MCDP_LF3_BIT],
                        st_ff.rx_lines_s2[1][`MCDP_LF2_BIT],
                        st_ff.rx_lines_s2[1][`MCDP_LF1_BIT],
                        st_ff.rx_lines_s2[1][`MCDP_STB_BIT]};
    stb_rise = st_ff.rx_lines_s2[1][`MCDP_STB_BIT] &
               ~st_ff.edge_prev[0];
    lf_rise  = nxt_st.edge_prev[3:1] & ~st_ff.edge_prev[3:1];
    // ------------------------------------------------------------------
    // strobed parity flag
    // ------------------------------------------------------------------
    par_grp = {st_ff.rx_lines_s2[1][`MCDP_PAR_BIT], st_ff.fb_s2[4]};
    if (internal_action_command.par_clr)
      nxt_st.par_raw = 1'b0;
    if (internal_action_command.par_set)
      nxt_st.par_raw = 1'b1;
    if (stb_rise)
      nxt_st.par_raw = odd_par(par_grp);
    nxt_st.par_sync = st_ff.par_raw;
    // ------------------------------------------------------------------
    // line flags: edge beats commands
    // ------------------------------------------------------------------
    for (int k = 0; k < 3; k++) begin
      if (internal_action_command.lf_clr[k])
        nxt_st.line_flag[k] = 1'b0;
      if (internal_action_command.lf_set[k] | lf_rise[k])
        nxt_st.line_flag[k] = 1'b1;
    end
    // ------------------------------------------------------------------
    // device multiplexer and receive bus
    // ------------------------------------------------------------------
    unique case (rd_sel)
      `MCDP_SEL_IN7: sel_byte = st_ff.rx_lines_s2[0];
      `MCDP_SEL_IN8: sel_byte = st_ff.rx_lines_s2[1];
      default: begin
        sel_byte = rd_src ? st_ff.out_reg[rd_sel]
                          : st_ff.fb_s2[rd_sel];
      end
    endcase
    if (internal_action_command.latch_mux_par)
      nxt_st.mux_par = odd_par({1'b0, sel_byte});
    nxt_st.rx_bus = rot_en ? {sel_byte[0], sel_byte[7:1]}
                           : sel_byte;
    // ------------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------------
    if (wr_en && wr_sel < 3'h6)
      nxt_st.out_reg[wr_sel] = tx_bus;
    if (init_cmd) begin
      nxt_st.out_reg[0] = `MCDP_OUT_RST;
      nxt_st.out_reg[2] = `MCDP_OUT_RST;
      nxt_st.out_reg[4] = `MCDP_OUT_RST;
      nxt_st.out_reg[5] = `MCDP_OUT_RST;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // microcode keeps readback only after a settle interval
  // (two cycles, under its own control)
  // crystal rate only sets mclk; no logic depends on it
  // clearing strobed parity near a strobe is left to microcode

  logic [47:0] oe_n_ff;
  always_ff @(posedge mclk) begin
    if (rst)
      oe_n_ff <= '1;
    else
      oe_n_ff <= '0;
  end

  assign line_out    = st_ff.out_reg;
  assign line_oe_n   = oe_n_ff;
  assign receive_bus = st_ff.rx_bus;
  assign jump = '{strobed_par: st_ff.par_sync, line_flag: st_ff.line_flag,
                  mux_par: st_ff.mux_par};

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_init_clears: assert property (init_cmd |=> st_ff.out_reg[0] == 8'h00 &&
      st_ff.out_reg[4] == 8'h00) else $error("init did not clear");
  chk_write_lands: assert property (wr_en && wr_sel == 3'h1 && !init_cmd
      |=> st_ff.out_reg[1] == $past(tx_bus)) else $error("write lost");
  chk_edge_wins: assert property (lf_rise[2] && internal_action_command.lf_clr[2]
      |=> jump.line_flag[2]) else $error("edge lost to clear");
  chk_cmd_clear: assert property (internal_action_command.lf_clr[0] && !internal_action_command.lf_set[0] &&
      !lf_rise[0] |=> !jump.line_flag[0]) else $error("clear failed");
  chk_par_delay: assert property (stb_rise |=> ##1
      jump.strobed_par == $past(odd_par(par_grp), 2)) else
      $error("strobed parity wrong");
  chk_par_set: assert property (internal_action_command.par_set && !stb_rise
      |=> ##1 jump.strobed_par) else $error("parity set failed");
  chk_rotate: assert property (rot_en && rd_sel == 3'h7 |=>
      receive_bus == {$past(st_ff.rx_lines_s2[1][0]),
      $past(st_ff.rx_lines_s2[1][7:1])}) else $error("rotate wrong");
  chk_reg_read: assert property (rd_src && !rot_en && rd_sel == 3'h2 |=>
      receive_bus == $past(st_ff.out_reg[2])) else $error("read wrong");
  chk_mux_par: assert property (internal_action_command.latch_mux_par |=>
      ^{jump.mux_par, $past(sel_byte)}) else $error("mux parity");

  cov_strobe:  cover property (stb_rise);
  cov_flag1:   cover property (lf_rise[0]);
  cov_rotread: cover property (rot_en && rd_src);
  cov_parclr:  cover property (internal_action_command.par_clr);
  cov_initcmd: cover property (init_cmd);

  // ------------------------------------------------------------------
  // output register writes
  // ------------------------------------------------------------------
  chk_write_b0: assert property (wr_en && wr_sel == 3'h0 && !init_cmd
      |=> st_ff.out_reg[0] == $past(tx_bus))
      else $error("write to byte one lost");

  chk_write_b2: assert property (wr_en && wr_sel == 3'h2 && !init_cmd
      |=> st_ff.out_reg[2] == $past(tx_bus))
      else $error("write to byte three lost");

  chk_write_b3: assert property (wr_en && wr_sel == 3'h3 && !init_cmd
      |=> st_ff.out_reg[3] == $past(tx_bus))
      else $error("write to byte four lost");

  chk_write_b4: assert property (wr_en && wr_sel == 3'h4 && !init_cmd
      |=> st_ff.out_reg[4] == $past(tx_bus))
      else $error("write to byte five lost");

  chk_write_b5: assert property (wr_en && wr_sel == 3'h5 && !init_cmd
      |=> st_ff.out_reg[5] == $past(tx_bus))
      else $error("write to byte six lost");

  chk_no_write: assert property (!wr_en && !init_cmd
      |=> line_out == $past(line_out))
      else $error("output bytes changed without write");

  chk_bad_sel: assert property (wr_en && wr_sel > 3'h5 && !init_cmd
      |=> line_out == $past(line_out))
      else $error("write to unused index landed");

  // ------------------------------------------------------------------
  // initialize
  // ------------------------------------------------------------------
  chk_init_keeps: assert property (init_cmd && !wr_en
      |=> st_ff.out_reg[1] == $past(st_ff.out_reg[1]) &&
          st_ff.out_reg[3] == $past(st_ff.out_reg[3]))
      else $error("init touched bytes two or four");

  chk_init_rest: assert property (init_cmd
      |=> st_ff.out_reg[2] == 8'h00 && st_ff.out_reg[5] == 8'h00)
      else $error("init left bytes three or six");

  // ------------------------------------------------------------------
  // selector and receive bus
  // ------------------------------------------------------------------
  chk_in7_read: assert property (rd_sel == 3'h6 && !rot_en
      |=> receive_bus == $past(st_ff.rx_lines_s2[0]))
      else $error("byte seven read wrong");

  chk_in8_read: assert property (rd_sel == 3'h7 && !rot_en
      |=> receive_bus == $past(st_ff.rx_lines_s2[1]))
      else $error("byte eight read wrong");

  chk_line_rd0: assert property (!rd_src && !rot_en && rd_sel == 3'h0
      |=> receive_bus == $past(st_ff.fb_s2[0]))
      else $error("line byte one read wrong");

  chk_line_rd1: assert property (!rd_src && !rot_en && rd_sel == 3'h1
      |=> receive_bus == $past(st_ff.fb_s2[1]))
      else $error("line byte two read wrong");

  chk_line_rd2: assert property (!rd_src && !rot_en && rd_sel == 3'h2
      |=> receive_bus == $past(st_ff.fb_s2[2]))
      else $error("line byte three read wrong");

  chk_line_rd3: assert property (!rd_src && !rot_en && rd_sel == 3'h3
      |=> receive_bus == $past(st_ff.fb_s2[3]))
      else $error("line byte four read wrong");

  chk_line_rd4: assert property (!rd_src && !rot_en && rd_sel == 3'h4
      |=> receive_bus == $past(st_ff.fb_s2[4]))
      else $error("line byte five read wrong");

  chk_line_rd5: assert property (!rd_src && !rot_en && rd_sel == 3'h5
      |=> receive_bus == $past(st_ff.fb_s2[5]))
      else $error("line byte six read wrong");

  chk_reg_rd0: assert property (rd_src && !rot_en && rd_sel == 3'h0
      |=> receive_bus == $past(st_ff.out_reg[0]))
      else $error("register byte one read wrong");

  chk_reg_rd5: assert property (rd_src && !rot_en && rd_sel == 3'h5
      |=> receive_bus == $past(st_ff.out_reg[5]))
      else $error("register byte six read wrong");

  chk_mux_hold: assert property (!internal_action_command.latch_mux_par
      |=> jump.mux_par == $past(jump.mux_par))
      else $error("mux parity moved without command");

  // ------------------------------------------------------------------
  // synchronizers and flags
  // ------------------------------------------------------------------
  chk_sync_pipe: assert property (
      st_ff.rx_lines_s2 == $past(st_ff.rx_lines_s1))
      else $error("input byte stage skipped");

  chk_fb_pipe: assert property (
      st_ff.fb_s2 == $past(st_ff.fb_s1))
      else $error("readback stage skipped");

  chk_lf_hold: assert property (!lf_rise[1] && !internal_action_command.lf_set[1] &&
      !internal_action_command.lf_clr[1] |=> jump.line_flag[1] == $past(jump.line_flag[1]))
      else $error("line flag two moved");

  chk_lf_setcmd: assert property (internal_action_command.lf_set[2]
      |=> jump.line_flag[2])
      else $error("line flag three set failed");

  chk_lf_edge1: assert property (lf_rise[0]
      |=> jump.line_flag[0])
      else $error("line flag one missed edge");

  chk_par_hold: assert property (!stb_rise && !internal_action_command.par_set &&
      !internal_action_command.par_clr |=> st_ff.par_raw == $past(st_ff.par_raw))
      else $error("strobed parity moved");

  chk_par_clr: assert property (internal_action_command.par_clr && !internal_action_command.par_set &&
      !stb_rise |=> ##1 !jump.strobed_par)
      else $error("strobed parity clear failed");

endmodule
`default_nettype wire

// file: bench/mcdp_periph.sv
// peripheral model: echoes the driven lines, supplies bytes seven and eight
// assumes open-collector drivers with pull-ups on every line
`timescale 1ns/1ps
`default_nettype none
module mcdp_periph (
  input  wire logic [47:0] line_out,  // driver data
  input  wire logic [47:0] line_oe_n, // driver enable, low on
  input  wire logic [15:0] dev_bytes, // bytes eight and seven to send
  output logic [47:0]      line_in,   // line levels seen
  output logic [7:0]       in7,       // byte seven
  output logic [7:0]       in8        // byte eight
);
  // released lines float up to the pull-up level
  assign line_in = line_out | line_oe_n;
  assign {in8, in7} = dev_bytes;
endmodule
`default_nettype wire

// file: bench/tb_mcdp_device_port.sv
// testbench of the controller device port
// assumes mcdp_pkg compiled and the peripheral model beside it
`timescale 1ns/1ps
`default_nettype none
module tb_mcdp_device_port;
  import mcdp_pkg::*;
  logic mclk = 0, rst = 1, init_cmd = 0, wr_en = 0, rd_src = 0, rot_en = 0;
  logic [2:0]  wr_sel = '0, rd_sel = '0;
  logic [15:0] dev_bytes = 16'h985a;
  logic [47:0] line_in, line_out, line_oe_n;
  mcdp_byte_t  tx_bus = '0, in7, in8, receive_bus;
  mcdp_iac_t   internal_action_command = '0;
  mcdp_jump_t  jump;
  int fails = 0, checks_done = 0;
  always #5 mclk = ~mclk;
  mcdp_device_port i_mcdp_device_port (.mclk(mclk), .rst(rst),
    .init_cmd(init_cmd), .tx_bus(tx_bus), .wr_sel(wr_sel), .wr_en(wr_en),
    .rd_sel(rd_sel), .rd_src(rd_src), .rot_en(rot_en), .internal_action_command(internal_action_command),
    .line_in(line_in), .in7(in7), .in8(in8), .line_out(line_out),
    .line_oe_n(line_oe_n), .receive_bus(receive_bus), .jump(jump));
  mcdp_periph i_mcdp_periph (.line_out(line_out), .line_oe_n(line_oe_n),
    .dev_bytes(dev_bytes), .line_in(line_in), .in7(in7), .in8(in8));
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(string what, logic [47:0] seen, logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge mclk);
  endtask
  function automatic mcdp_byte_t pat(int i);
    return 8'h3c ^ 8'(i * 8'h47);
  endfunction
  task automatic wr(int idx, mcdp_byte_t d);
    wr_sel = idx[2:0];
    tx_bus = d;
    wr_en = 1;
    cyc(1);
    wr_en = 0;
    cyc(1);
  endtask
  task automatic rd(int sel, logic src, logic rot, output mcdp_byte_t v);
    rd_sel = sel[2:0];
    rd_src = src;
    rot_en = rot;
    cyc(1);
    v = receive_bus;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    mcdp_byte_t v;
    mcdp_byte_t p;
    logic [47:0] e;
    cyc(2);
    chk("oe_in_reset", line_oe_n, '1);
    cyc(2);
    rst = 0;
    cyc(2);
    chk("oe_on", line_oe_n, '0);
    chk("flags_rst", jump, '0);
    for (int i = 0; i < 6; i++) wr(i, pat(i));
    wr(6, 8'hff);
    for (int i = 0; i < 6; i++) e[8*i +: 8] = pat(i);
    chk("line_out", line_out, e);
    cyc(3);
    for (int i = 0; i < 6; i++) begin
      rd(i, 1, 0, v);
      chk("reg_src", v, pat(i));
      rd(i, 0, 1, v);
      p = pat(i);
      chk("line_rot", v, {p[0], p[7:1]});
    end
    rd(6, 0, 0, v);
    chk("byte7", v, 8'h5a);
    rd(7, 0, 1, v);
    chk("byte8_rot", v, 8'h4c);
    for (int s = 6; s < 8; s++) begin
      rd(s, 0, 0, v);
      internal_action_command.latch_mux_par = 1;
      cyc(1);
      internal_action_command = '0;
      cyc(1);
      chk("mux_par", jump.mux_par, s == 6);
    end
    dev_bytes[10:8] = 3'b111;
    cyc(4);
    chk("lf_edge", jump.line_flag, 3'b111);
    internal_action_command.lf_clr = 3'b111;
    cyc(1);
    internal_action_command = '0;
    cyc(1);
    chk("lf_clr", jump.line_flag, 3'b000);
    internal_action_command.lf_set = 3'b010;
    cyc(1);
    internal_action_command = '0;
    cyc(1);
    chk("lf_set", jump.line_flag, 3'b010);
    for (int k = 0; k < 2; k++) begin
      wr(4, k ? 8'h03 : 8'h01);
      dev_bytes[10] = 0;
      cyc(4);
      internal_action_command.par_clr = 1;
      cyc(1);
      internal_action_command = '0;
      cyc(1);
      chk("par_clr", jump.strobed_par, 1'b0);
      dev_bytes[10] = 1;
      cyc(5);
      chk("par_strobe", jump.strobed_par, k == 1);
      internal_action_command.par_set = 1;
      cyc(1);
      internal_action_command = '0;
      cyc(1);
      chk("par_set", jump.strobed_par, 1'b1);
    end
    init_cmd = 1;
    cyc(1);
    init_cmd = 0;
    chk("init", line_out, {16'h0, pat(3), 8'h0, pat(1), 8'h0});
    conclude();
  end
  initial begin
    #100000;
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
